// file: nfc_regs.vh
// Register offsets, field positions, reset values and counts of the flash block
`ifndef NFC_REGS_VH
`define NFC_REGS_VH

// ---------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define NFC_PIN_ECC_IDX     16'h08c0
`define NFC_CFG_STAT_IDX    16'h08c2

// ---------------------------------------------------------------------------
// flash_pin_ecc_control fields
// ---------------------------------------------------------------------------
`define NFC_B_ECC_CLEAR     0
`define NFC_B_BUSY          1
`define NFC_B_ECC_ENABLE    2
`define NFC_B_CE1           3
`define NFC_B_CE0           4
`define NFC_B_CLE           5
`define NFC_B_ALE           6
`define NFC_B_WE            7
`define NFC_B_ECC_RD_SEL    8
`define NFC_B_CALC_START    9
`define NFC_B_ENC_DEC       10
`define NFC_B_INT_LATCH     11
`define NFC_F_HIGH_W        13:12
`define NFC_F_LOW_W         15:14
`define NFC_PIN_ECC_RST     16'h0000

// ---------------------------------------------------------------------------
// flash_config_status fields
// ---------------------------------------------------------------------------
`define NFC_B_CLK_EN        0
`define NFC_B_CODE_SEL      1
`define NFC_B_BUS_WIDE      2
`define NFC_B_CALC_IRQ_EN   6
`define NFC_B_RDY_IRQ_EN    7
`define NFC_F_ERR_CNT       11:10
`define NFC_F_CALC_STATE    15:12
`define NFC_CFG_STAT_RST    16'h0000

// ---------------------------------------------------------------------------
// Calculation states and timing counts
// ---------------------------------------------------------------------------
`define NFC_CALC_OK         4'h0
`define NFC_CALC_UNCORR     4'h1
`define NFC_CALC_ERRS       4'h2
`define NFC_CALC_RUNNING    4'h4
`define NFC_ECC_GUARD_CYC   5'h14
`define NFC_FILTER_LEN      4
`define NFC_CODE_W          80

`endif

// file: nfc_strobe.v
// Read and write strobe timing generator for the flash data path
`timescale 1ns/1ns

module nfc_strobe (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       run,
  input  wire       req,
  input  wire       write,
  input  wire       we_en,
  input  wire [1:0] high_w,
  input  wire [1:0] low_w,
  output reg        re_n,
  output reg        we_n,
  output wire       done
);

  // ---------------------------------------------------------------------------
  // States
  // ---------------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LOW  = 3'b010;
  localparam [2:0] ST_HIGH = 3'b100;

  reg [2:0] state;
  reg [1:0] cnt;
  reg       is_write;

  assign done = run & (state == ST_HIGH) & (cnt == 2'b00);

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      cnt      <= 2'b00;
      is_write <= 1'b0;
      re_n     <= 1'b1;
      we_n     <= 1'b1;
    end else if (run) begin
      case (state)
        ST_IDLE: begin
          if (req) begin
            state    <= ST_LOW;
            cnt      <= low_w;
            is_write <= write;
            re_n     <= write;
            // Without write enable the cycle runs but no write strobe leaves
            we_n     <= ~(write & we_en);
          end
        end
        ST_LOW: begin
          if (cnt == 2'b00) begin
            state <= ST_HIGH;
            cnt   <= high_w;
            re_n  <= 1'b1;
            we_n  <= 1'b1;
          end else begin
            cnt <= cnt - 2'b01;
          end
        end
        ST_HIGH: begin
          if (cnt == 2'b00) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 2'b01;
          end
        end
        default: begin
          state <= ST_IDLE;
          re_n  <= 1'b1;
          we_n  <= 1'b1;
        end
      endcase
    end
  end

endmodule // nfc_strobe

// file: nfc_ctrl.v
// Flash controller mode, pin and ECC control registers with APB access
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`include "nfc_regs.vh"

module nfc_ctrl (
  input  wire                    CLOCK,
  input  wire                    RST_N,
  input  wire                    CE,
  // APB slave
  input  wire                    PSEL,
  input  wire                    PENABLE,
  input  wire                    PWRITE,
  input  wire [15:0]             PADDR,
  input  wire [31:0]             PWDATA,
  input  wire [3:0]              PSTRB,
  output wire                    PREADY,
  output reg  [31:0]             PRDATA,
  output wire                    PSLVERR,
  // Flash pins
  input  wire                    FLASH_READY_BUSY_IN,
  output wire                    FLASH_CE0_N,
  output wire                    FLASH_CE1_N,
  output wire                    FLASH_CLE,
  output wire                    FLASH_ALE,
  output wire                    READ_STROBE_N,
  output wire                    WRITE_STROBE_N,
  output wire                    BUS_WIDE,
  // Data transfer requests
  input  wire                    XFER_REQ,
  input  wire                    XFER_WRITE,
  output wire                    XFER_DONE,
  // ECC generator control
  output wire                    ECC_ENABLE,
  output wire                    CODE_SELECT,
  output reg                     HAMMING_CLEAR,
  output reg                     RS_CLEAR,
  output wire                    ECC_READ_SELECT,
  output wire                    ENCODE_DECODE,
  input  wire [`NFC_CODE_W-1:0]  GEN_CODE,
  // Error calculator
  output reg  [`NFC_CODE_W-1:0]  CALC_CODE,
  output reg                     CALC_START,
  input  wire                    CALC_END,
  input  wire                    CALC_UNCORR,
  input  wire                    CALC_ERR_FOUND,
  input  wire [1:0]              CALC_ERR_NUM,
  // Interrupt requests
  output reg                     READY_IRQ,
  output reg                     CALC_END_IRQ
);

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------
  function hit;
    input [15:0] addr;
    input [15:0] idx;
    begin
      hit = (addr == {idx[13:0], 2'b00});
    end
  endfunction

  reg  [15:0] pin_ecc;
  reg  [15:0] cfg;
  reg  [3:0]  calc_state;
  reg  [1:0]  error_count;
  reg  [`NFC_FILTER_LEN-1:0] rb_hist;
  reg         flt_ready;
  reg  [4:0]  guard_cnt;
  reg         start_pend;

  wire run      = CE & cfg[`NFC_B_CLK_EN];
  wire setup    = CE & PSEL & ~PENABLE;
  wire access   = CE & PSEL & PENABLE;
  wire sel_pin  = hit(PADDR, `NFC_PIN_ECC_IDX);
  wire sel_cfg  = hit(PADDR, `NFC_CFG_STAT_IDX);
  wire mapped   = sel_pin | sel_cfg;
  wire wr_pin   = access & PWRITE & sel_pin;
  wire wr_cfg   = access & PWRITE & sel_cfg;
  wire guard_on = (guard_cnt != 5'h00);
  wire flt_busy = ~flt_ready;
  wire rd_done;

  assign PREADY  = CE;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // ---------------------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------------------
  wire [1:0] ce_bits = {pin_ecc[`NFC_B_CE1], pin_ecc[`NFC_B_CE0]};
  wire [1:0] ce_pins;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ce
      assign ce_pins[g] = ~ce_bits[g];
    end
  endgenerate
  assign FLASH_CE0_N = ce_pins[0];
  assign FLASH_CE1_N = ce_pins[1];
  assign FLASH_CLE   = pin_ecc[`NFC_B_CLE];
  assign FLASH_ALE   = pin_ecc[`NFC_B_ALE];
  assign BUS_WIDE    = cfg[`NFC_B_BUS_WIDE];

  assign ECC_ENABLE      = pin_ecc[`NFC_B_ECC_ENABLE];
  assign CODE_SELECT     = cfg[`NFC_B_CODE_SEL];
  assign ECC_READ_SELECT = pin_ecc[`NFC_B_ECC_RD_SEL];
  assign ENCODE_DECODE   = pin_ecc[`NFC_B_ENC_DEC];

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  // Clear and start bits are actions, never stored
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pin_ecc <= `NFC_PIN_ECC_RST;
      cfg     <= `NFC_CFG_STAT_RST;
    end else if (CE) begin
      if (wr_pin) begin
        if (PSTRB[0]) begin
          pin_ecc[7:2] <= PWDATA[7:2];
        end
        if (PSTRB[1]) begin
          pin_ecc[15:10] <= PWDATA[15:10];
          pin_ecc[`NFC_B_ECC_RD_SEL] <= PWDATA[`NFC_B_ECC_RD_SEL];
        end
      end
      if (wr_cfg && PSTRB[0]) begin
        cfg[`NFC_B_CLK_EN]      <= PWDATA[`NFC_B_CLK_EN];
        cfg[`NFC_B_CODE_SEL]    <= PWDATA[`NFC_B_CODE_SEL];
        cfg[`NFC_B_BUS_WIDE]    <= PWDATA[`NFC_B_BUS_WIDE];
        cfg[`NFC_B_CALC_IRQ_EN] <= PWDATA[`NFC_B_CALC_IRQ_EN];
        cfg[`NFC_B_RDY_IRQ_EN]  <= PWDATA[`NFC_B_RDY_IRQ_EN];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------------------
  // Data captured in the setup phase so it stands through the access phase
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup) begin
      if (sel_pin) begin
        PRDATA <= {16'h0000, pin_ecc[15:10], 1'b0,
                   pin_ecc[`NFC_B_ECC_RD_SEL], pin_ecc[7:2],
                   flt_busy, 1'b0};
      end else if (sel_cfg) begin
        PRDATA <= {16'h0000, calc_state, error_count,
                   2'b00, cfg[7:6], 3'b000, cfg[2:0]};
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // ECC clear actions
  // ---------------------------------------------------------------------------
  wire clr_req = wr_pin & PSTRB[0] & PWDATA[`NFC_B_ECC_CLEAR];

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      HAMMING_CLEAR <= 1'b0;
      RS_CLEAR      <= 1'b0;
    end else if (CE) begin
      // Enable is sampled as stored before this write
      HAMMING_CLEAR <= clr_req & pin_ecc[`NFC_B_ECC_ENABLE]
                       & ~cfg[`NFC_B_CODE_SEL];
      RS_CLEAR      <= clr_req & pin_ecc[`NFC_B_ECC_ENABLE]
                       & cfg[`NFC_B_CODE_SEL];
    end
  end

  // ---------------------------------------------------------------------------
  // Ready/busy noise filter and ready interrupt
  // ---------------------------------------------------------------------------
  // The flag moves only after the pin holds a level for the whole window,
  // so software must allow that latency before polling
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rb_hist   <= {`NFC_FILTER_LEN{1'b1}};
      flt_ready <= 1'b1;
      READY_IRQ <= 1'b0;
    end else if (run) begin
      rb_hist <= {rb_hist[`NFC_FILTER_LEN-2:0], FLASH_READY_BUSY_IN};
      if (&rb_hist) begin
        flt_ready <= 1'b1;
      end else if (~|rb_hist) begin
        flt_ready <= 1'b0;
      end
      READY_IRQ <= (&rb_hist) & ~flt_ready
                   & cfg[`NFC_B_RDY_IRQ_EN];
    end else if (CE) begin
      // Controller clock off: no pulse, but a low CE still freezes it
      READY_IRQ <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Strobe generator
  // ---------------------------------------------------------------------------
  // No access begins during the guard after a stored-ECC read
  wire xfer_go = XFER_REQ & ~guard_on;

  nfc_strobe u_strobe (
    .clk    (CLOCK),
    .rst_n  (RST_N),
    .run    (run),
    .req    (xfer_go),
    .write  (XFER_WRITE),
    .we_en  (pin_ecc[`NFC_B_WE]),
    .high_w (pin_ecc[`NFC_F_HIGH_W]),
    .low_w  (pin_ecc[`NFC_F_LOW_W]),
    .re_n   (READ_STROBE_N),
    .we_n   (WRITE_STROBE_N),
    .done   (XFER_DONE)
  );

  assign rd_done = XFER_DONE & ~XFER_WRITE;

  // ---------------------------------------------------------------------------
  // Guard after a stored-ECC read
  // ---------------------------------------------------------------------------
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      guard_cnt <= 5'h00;
    end else if (run) begin
      if (rd_done && pin_ecc[`NFC_B_ECC_RD_SEL]) begin
        guard_cnt <= `NFC_ECC_GUARD_CYC;
      end else if (guard_on) begin
        guard_cnt <= guard_cnt - 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Error calculation start and status
  // ---------------------------------------------------------------------------
  wire start_req = wr_pin & PSTRB[1] & PWDATA[`NFC_B_CALC_START];
  wire start_now = start_pend & run & ~guard_on;

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      start_pend   <= 1'b0;
      CALC_START   <= 1'b0;
      calc_state   <= `NFC_CALC_OK;
      error_count  <= 2'b00;
      CALC_END_IRQ <= 1'b0;
    end else if (CE) begin
      // A new request is kept even if it lands on the launch cycle
      start_pend   <= start_req | (start_pend & ~start_now);
      CALC_START   <= start_now;
      CALC_END_IRQ <= 1'b0;
      if (start_now) begin
        calc_state <= `NFC_CALC_RUNNING;
      end else if (run && CALC_END) begin
        if (CALC_UNCORR) begin
          calc_state <= `NFC_CALC_UNCORR;
        end else if (CALC_ERR_FOUND) begin
          calc_state <= `NFC_CALC_ERRS;
        end else begin
          calc_state <= `NFC_CALC_OK;
        end
        error_count  <= CALC_ERR_NUM;
        CALC_END_IRQ <= cfg[`NFC_B_CALC_IRQ_EN];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Intermediate code hand-off to the calculator
  // ---------------------------------------------------------------------------
  // Holding the code lets the generator start the next page while the
  // calculator is still busy on this one
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      CALC_CODE <= {`NFC_CODE_W{1'b0}};
    end else if (run && !pin_ecc[`NFC_B_INT_LATCH]) begin
      CALC_CODE <= GEN_CODE;
    end
  end

endmodule // nfc_ctrl

// file: nfc_ctrl_props.sv
// Port-level assertions for the flash control block
`timescale 1ns/1ns
`include "nfc_regs.vh"
module nfc_ctrl_props (
  input logic                   CLOCK,
  input logic                   RST_N,
  input logic                   CE,
  input logic                   PSEL,
  input logic                   PENABLE,
  input logic                   PWRITE,
  input logic [15:0]            PADDR,
  input logic [31:0]            PWDATA,
  input logic                   PSLVERR,
  input logic                   FLASH_READY_BUSY_IN,
  input logic                   FLASH_CE0_N,
  input logic                   FLASH_CLE,
  input logic                   READ_STROBE_N,
  input logic                   WRITE_STROBE_N,
  input logic                   BUS_WIDE,
  input logic                   XFER_REQ,
  input logic                   XFER_WRITE,
  input logic                   XFER_DONE,
  input logic                   ECC_ENABLE,
  input logic                   CODE_SELECT,
  input logic                   HAMMING_CLEAR,
  input logic                   RS_CLEAR,
  input logic [`NFC_CODE_W-1:0] GEN_CODE,
  input logic [`NFC_CODE_W-1:0] CALC_CODE,
  input logic                   CALC_END,
  input logic                   READY_IRQ,
  input logic                   CALC_END_IRQ
);
  localparam logic [15:0] PIN_A = `NFC_PIN_ECC_IDX << 2;
  localparam logic [15:0] CFG_A = `NFC_CFG_STAT_IDX << 2;
  wire wr     = PSEL && PENABLE && CE && PWRITE;
  wire wr_pin = wr && PADDR == PIN_A;
  wire wr_cfg = wr && PADDR == CFG_A;
  wire clr    = wr_pin && PWDATA[0];
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  a_pins_follow: assert property (wr_pin |=>
    FLASH_CE0_N == !$past(PWDATA[4]) && FLASH_CLE == $past(PWDATA[5]))
    else $error("flash pins do not follow the write");
  a_clear_blocked: assert property (clr && !ECC_ENABLE |=>
    !HAMMING_CLEAR && !RS_CLEAR) else $error("clear while disabled");
  a_clear_hamming: assert property (clr && ECC_ENABLE && !CODE_SELECT |=>
    HAMMING_CLEAR && !RS_CLEAR) else $error("hamming clear wrong");
  a_clear_rs: assert property (clr && ECC_ENABLE && CODE_SELECT |=>
    RS_CLEAR && !HAMMING_CLEAR) else $error("rs clear wrong");
  a_cfg_follow: assert property (wr_cfg |=>
    BUS_WIDE == $past(PWDATA[2]) && CODE_SELECT == $past(PWDATA[1]))
    else $error("config outputs do not follow the write");
  a_unmapped_err: assert property (PSEL && PENABLE && PADDR != PIN_A
    && PADDR != CFG_A |-> PSLVERR) else $error("no error on unmapped");
  a_done_idle: assert property (XFER_DONE |->
    READ_STROBE_N && WRITE_STROBE_N) else $error("done during low phase");
  a_low_bounded: assert property ($fell(READ_STROBE_N) |->
    ##[1:4] READ_STROBE_N) else $error("read low phase too long");
  a_write_gate: assert property (!WRITE_STROBE_N |->
    XFER_REQ && XFER_WRITE) else $error("write strobe without write");
  a_code_source: assert property ($changed(CALC_CODE) |->
    CALC_CODE == $past(GEN_CODE)) else $error("calc code not from gen");
  a_irq_filtered: assert property (READY_IRQ |->
    FLASH_READY_BUSY_IN && $past(FLASH_READY_BUSY_IN, 4))
    else $error("ready interrupt without stable ready");
  a_calc_irq_src: assert property (CALC_END_IRQ |->
    $past(CALC_END)) else $error("calc interrupt without end");
endmodule // nfc_ctrl_props
bind nfc_ctrl nfc_ctrl_props props_u (.*);

// file: nfc_flash_model.sv
// Behavioural flash device: goes busy after a command strobe
`timescale 1ns/1ns
module nfc_flash_model (
  input  logic       clock,
  input  logic       rst_n,
  input  logic       ce_n,
  input  logic       cle,
  input  logic       we_n,
  input  logic [7:0] busy_len,
  output logic       ready
);
  logic [7:0] left;
  logic       we_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      left <= 8'h00;
      we_q <= 1'b1;
    end else begin
      we_q <= we_n;
      if (we_n && !we_q && !ce_n && cle) begin
        left <= busy_len;
      end else if (left != 8'h00) begin
        left <= left - 8'h01;
      end
    end
  end
  // Pulled-up line, clean edges only: the filter never sees a glitch
  assign ready = (left == 8'h00);
endmodule // nfc_flash_model

// file: nand_flash_ctrl_mode_regs_bench.sv
// Self-checking bench for the flash control block
`timescale 1ns/1ns
`include "nfc_regs.vh"
module nand_flash_ctrl_mode_regs_bench;
  localparam logic [15:0] PIN_A = `NFC_PIN_ECC_IDX << 2;
  localparam logic [15:0] CFG_A = `NFC_CFG_STAT_IDX << 2;
  logic        CLOCK, RST_N, CE, PSEL, PENABLE, PWRITE, XFER_REQ, XFER_WRITE;
  logic        CALC_END, CALC_UNCORR, CALC_ERR_FOUND, PREADY, PSLVERR;
  logic        FLASH_READY_BUSY_IN, FLASH_CE0_N, FLASH_CE1_N, FLASH_CLE;
  logic        FLASH_ALE, READ_STROBE_N, WRITE_STROBE_N, BUS_WIDE, XFER_DONE;
  logic        ECC_ENABLE, CODE_SELECT, HAMMING_CLEAR, RS_CLEAR, CALC_START;
  logic        ECC_READ_SELECT, ENCODE_DECODE, READY_IRQ, CALC_END_IRQ, err;
  logic [15:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd, d;
  logic [3:0]  PSTRB;
  logic [1:0]  CALC_ERR_NUM;
  logic [79:0] GEN_CODE, CALC_CODE, held, g;
  logic [7:0]  busy_len;
  logic [31:0] exp_q[$];
  int          errors, samples_checked, seed, rdy_irqs, calc_irqs, lo, hi, n;
  nfc_ctrl dut_u (.*);
  nfc_flash_model flash_u (.clock(CLOCK), .rst_n(RST_N), .ce_n(FLASH_CE0_N),
    .cle(FLASH_CLE), .we_n(WRITE_STROBE_N), .busy_len(busy_len),
    .ready(FLASH_READY_BUSY_IN));
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end
  task check(input string name, input logic [79:0] e, input logic [79:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    #1;
  endtask
  task rdc(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // Counts strobe low and high cycles up to the done pulse
  task xfer(input logic w);
    lo = 0;
    hi = 0;
    n = 0;
    @(posedge CLOCK);
    XFER_REQ <= 1'b1;
    XFER_WRITE <= w;
    do begin
      @(posedge CLOCK);
      #1;
      n++;
      if (READ_STROBE_N !== 1'b1 || WRITE_STROBE_N !== 1'b1) lo++;
      else if (lo > 0) hi++;
    end while (XFER_DONE !== 1'b1 && n < 200);
    if (XFER_DONE !== 1'b1) errors++;
    @(posedge CLOCK);
    XFER_REQ <= 1'b0;
  endtask
  always @(posedge CLOCK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && exp_q.size() > 0)
      check("prdata", exp_q.pop_front(), PRDATA);
    if (READY_IRQ === 1'b1) rdy_irqs++;
    if (CALC_END_IRQ === 1'b1) calc_irqs++;
  end
  task test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    test_done;
  end
  initial begin
    {PSEL, PENABLE, PWRITE, XFER_REQ, XFER_WRITE, CALC_END} = 6'h00;
    {CALC_UNCORR, CALC_ERR_FOUND, CALC_ERR_NUM, PADDR, PWDATA} = 0;
    {GEN_CODE, held, errors, samples_checked, rdy_irqs, calc_irqs} = 0;
    CE = 1'b1;
    PSTRB = 4'hf;
    busy_len = 8'h28;
    seed = 94308;
    RST_N = 1'b0;
    repeat (12) @(posedge CLOCK);
    RST_N <= 1'b1;
    rdc(PIN_A, 32'h0000_0000);
    rdc(CFG_A, 32'h0000_0000);
    check("ce0_n", 1'b1, FLASH_CE0_N);
    XFER_REQ <= 1'b1;
    repeat (8) @(posedge CLOCK);
    check("gated", 1'b1, READ_STROBE_N);
    XFER_REQ <= 1'b0;
    @(posedge CLOCK);
    CE <= 1'b0;
    @(posedge CLOCK);
    #1;
    check("pready", 1'b0, PREADY);
    CE <= 1'b1;
    rdc(PIN_A + 16'h0004, 32'h0000_0000);
    check("pslverr", 1'b1, err);
    apb(1'b1, CFG_A, 32'h0000_0087);
    rdc(CFG_A, 32'h0000_0087);
    check("bus_wide", 1'b1, BUS_WIDE);
    $display("test reset and config done");
    for (int i = 0; i < 8; i++) begin
      d = $random(seed) & 32'h0000_fd7c;
      g = {16'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      apb(1'b1, PIN_A, d);
      check("pins", {~d[3], ~d[4], d[5], d[6]},
            {FLASH_CE1_N, FLASH_CE0_N, FLASH_CLE, FLASH_ALE});
      check("ecc_sel", {d[2], d[8], d[10]},
            {ECC_ENABLE, ECC_READ_SELECT, ENCODE_DECODE});
      rdc(PIN_A, d);
      GEN_CODE <= g;
      repeat (2) @(posedge CLOCK);
      #1;
      if (!d[11]) held = g;
      check("calc_code", held, CALC_CODE);
    end
    $display("test pins done");
    apb(1'b1, CFG_A, 32'h0000_0081);
    // Enable must already be off before the clear write for the blocked case
    apb(1'b1, PIN_A, 32'h0000_0000);
    apb(1'b1, PIN_A, 32'h0000_0001);
    check("clr_off", 2'b00, {HAMMING_CLEAR, RS_CLEAR});
    apb(1'b1, PIN_A, 32'h0000_0004);
    apb(1'b1, PIN_A, 32'h0000_0005);
    check("clr_ham", 2'b10, {HAMMING_CLEAR, RS_CLEAR});
    apb(1'b1, CFG_A, 32'h0000_0083);
    apb(1'b1, PIN_A, 32'h0000_0005);
    check("clr_rs", 2'b01, {HAMMING_CLEAR, RS_CLEAR});
    $display("test ecc clear done");
    for (int k = 0; k < 5; k++) begin
      if (k == 4) apb(1'b1, CFG_A, 32'h0000_0003);
      d = 32'h0000_00b0 | (k % 4) << 14 | (3 - k % 4) << 12;
      apb(1'b1, PIN_A, d);
      xfer(1'b1);
      check("low_w", 1 + k % 4, lo);
      check("high_w", 4 - k % 4, hi);
      repeat (10) @(posedge CLOCK);
      rdc(PIN_A, d | 32'h0000_0002);
      repeat (60) @(posedge CLOCK);
      rdc(PIN_A, d);
    end
    check("rdy_irqs", 4, rdy_irqs);
    apb(1'b1, PIN_A, 32'h0000_0010);
    xfer(1'b1);
    check("we_off", 0, lo);
    xfer(1'b0);
    check("rd_data", 1, lo);
    apb(1'b1, PIN_A, 32'h0000_0110);
    xfer(1'b0);
    check("rd_low", 1, lo);
    check("no_guard", 2, n);
    xfer(1'b0);
    check("guard", 1'b1, n > 20);
    $display("test strobes done");
    repeat (25) @(posedge CLOCK);
    apb(1'b1, CFG_A, 32'h0000_00c3);
    // Error count keeps the last result until the next calculation ends
    lo = 0;
    for (int o = 0; o < 3; o++) begin
      d = 32'($random(seed)) & 32'h0000_0003;
      apb(1'b1, PIN_A, 32'h0000_0200);
      n = 0;
      while (CALC_START !== 1'b1 && n < 50) begin
        @(posedge CLOCK);
        #1;
        n++;
      end
      check("calc_start", 1'b1, CALC_START);
      rdc(CFG_A, 32'h0000_40c3 | lo << 10);
      @(posedge CLOCK);
      CALC_END <= 1'b1;
      CALC_UNCORR <= (o == 1);
      CALC_ERR_FOUND <= (o == 2);
      CALC_ERR_NUM <= d[1:0];
      @(posedge CLOCK);
      CALC_END <= 1'b0;
      repeat (2) @(posedge CLOCK);
      rdc(CFG_A, 32'h0000_00c3 | o << 12 | d << 10);
      lo = d;
    end
    check("calc_irqs", 3, calc_irqs);
    $display("test calculation done");
    test_done;
  end
endmodule // nand_flash_ctrl_mode_regs_bench
